// ===== dv/odac_host_model.sv
// Host-side model that frames the serial load port
`timescale 1ns/1ps
`include "odac_defines.svh"
module odac_host_model (
  output logic shift_clk,
  output logic select_n,
  output logic serial_in,
  output logic output_load_strobe_n,
  input  wire logic serial_out
);
  logic [15:0] echo;
  initial begin
    {shift_clk, select_n, serial_in, output_load_strobe_n} = 4'h5;
    echo = 16'h0;
  end
  // Clock stands low between frames
  task automatic send(input logic [15:0] w);
    select_n = 1'h0;
    #47;
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      #60 echo = {echo[14:0], serial_out};
      // Zero-delay echo, so this rate still reads back cleanly
      #20 shift_clk = 1'h1;
      #80 shift_clk = 1'h0;
    end
    #40 select_n = 1'h1;
    serial_in = ~serial_in;
    #100;
  endtask : send
  task automatic pulse();
    output_load_strobe_n = 1'h0;
    #`ODAC_STROBE_LOW_WIDTH_NS output_load_strobe_n = 1'h1;
  endtask : pulse
endmodule : odac_host_model

// ===== dv/odac_serial_port_monitor.sv
// Concurrent checks on the serial load port pins
`timescale 1ns/1ps
`include "odac_defines.svh"
module odac_serial_port_monitor (
  input wire logic                                mclk,
  input wire logic                                resetn,
  input wire logic                                shift_clk,
  input wire logic                                select_n,
  input wire logic                                serial_in,
  input wire logic                                output_load_strobe_n,
  input wire logic                                serial_out,
  input wire logic [`ODAC_CHANNELS*`ODAC_CODE_W-1:0] conv_code,
  input wire logic [`ODAC_CHANNELS-1:0]           chan_enable,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [`ODAC_ADDR_W-1:0]             paddr,
  input wire logic [31:0]                         pwdata,
  input wire logic [31:0]                         prdata,
  input wire logic                                pready,
  input wire logic                                pslverr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Eight quiet cycles outlast the sync delay of a pending command
  a_code_quiet: assert property ((select_n && output_load_strobe_n && !psel) [*8] |-> $stable(conv_code))
    else $error("output code moved with no cause");
  a_low_no_exec: assert property ((!select_n && output_load_strobe_n && !psel) [*8] |-> $stable(conv_code))
    else $error("output code moved inside a frame");
  a_enable_exec: assert property ($changed(chan_enable) |->
    $past(select_n, 1) || $past(select_n, 2) || $past(select_n, 3) || $past(select_n, 4))
    else $error("enables moved far from a frame end");
  a_idle_out: assert property (select_n [*2] |-> $stable(serial_out))
    else $error("serial output moved while deselected");
  a_reset_vals: assert property ($rose(resetn) |-> conv_code == 64'h0 && chan_enable == 8'hff && !serial_out)
    else $error("wrong values at reset release");
  a_ready_one: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_bad_write: assert property (pready && pwrite && paddr != `ODAC_REG_CTRL |-> pslverr)
    else $error("write to read-only place not refused");
  cover property ($rose(select_n));
  cover property (pready && pslverr);
  cover property ($fell(output_load_strobe_n));
endmodule : odac_serial_port_monitor
bind odac_serial_port odac_serial_port_monitor mon (.mclk, .resetn, .shift_clk, .select_n, .serial_in,
  .output_load_strobe_n, .serial_out, .conv_code, .chan_enable, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr);

// ===== dv/odac_serial_port_tb.sv
// Self-checking bench for the serial load port
`timescale 1ns/1ps
`include "odac_defines.svh"
module odac_serial_port_tb;
  import odac_pkg::*;
  localparam int CW = `ODAC_CHANNELS*`ODAC_CODE_W;
  logic        mclk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        shift_clk, select_n, serial_in, output_load_strobe_n, serial_out, pready, pslverr, er;
  logic [CW-1:0] conv_code;
  logic [7:0]  chan_enable;
  int          err_total = 0, samples_checked = 0;
  typedef struct {logic [15:0] f; logic [CW-1:0] c; logic [7:0] e;} odac_row_t;
  // Frame, then outputs expected once it has executed
  odac_row_t rows [8] = '{'{16'hd55a, 64'h0, 8'hff}, '{16'h0700, 64'h5a0000, 8'hff},
    '{16'h3ec3, 64'hc3000000005a0000 >> 4, 8'hff}, '{16'h0411, {8{8'h11}}, 8'hff},
    '{16'h020f, {8{8'h11}}, 8'h0f}, '{16'h02ff, {8{8'h11}}, 8'hff},
    '{16'h0100, 64'h0, 8'hff}, '{16'h2300, 64'h0, 8'hff}};
  odac_serial_port dut (.mclk, .resetn, .shift_clk, .select_n, .serial_in, .output_load_strobe_n,
    .serial_out, .conv_code, .chan_enable, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  odac_host_model host (.shift_clk, .select_n, .serial_in, .output_load_strobe_n, .serial_out);
  always #25 mclk = ~mclk;
  task automatic chk(input string s, input logic [CW-1:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge mclk) penable <= 1'h1;
    do @(posedge mclk) n++; while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    if (n >= 20) err_total++;
  endtask : apb
  // Command lands a few cycles after select rises
  task automatic frame(input logic [15:0] f);
    @(posedge mclk) #13 host.send(f);
    repeat (8) @(posedge mclk);
  endtask : frame
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    rows[2].c = 64'hc3000000005a0000;
    repeat (6) @(posedge mclk);
    resetn <= 1'h1;
    foreach (rows[i]) begin
      frame(rows[i].f);
      chk("echo", i > 0 ? rows[i-1].f : 16'h0, host.echo);
      chk("code", rows[i].c, conv_code);
      chk("enable", rows[i].e, chan_enable);
    end
    apb(1'h0, `ODAC_REG_STATUS, 32'h0);
    chk("phase", 1'h1, rd[`ODAC_ST_PHASE_BIT]);
    frame(16'h00a5);
    frame(16'h2577);
    chk("echo1", 16'h00a5 >> 1, host.echo[14:0]);
    chk("held", 64'h0, conv_code);
    // Off the edge, so the short pulse is seen by a system clock edge
    @(posedge mclk) #13 host.pulse();
    repeat (8) @(posedge mclk);
    chk("strobe", 64'h77 << 32, conv_code);
    frame(16'h0d99);
    apb(1'h0, 12'h024, 32'h0);
    chk("input1", 32'h99, rd);
    apb(1'h1, `ODAC_REG_CTRL, 32'h1);
    apb(1'h0, 12'h044, 32'h0);
    chk("output1", 32'h99, rd);
    apb(1'h1, `ODAC_REG_STATUS, 32'h1);
    chk("ro_err", 1'h1, er);
    apb(1'h0, 12'hffc, 32'h0);
    chk("map_err", 1'h1, er);
    @(posedge mclk) resetn <= 1'h0;
    repeat (3) @(posedge mclk);
    chk("rst_code", 64'h0, conv_code);
    chk("rst_out", 1'h0, serial_out);
    resetn <= 1'h1;
    apb(1'h0, `ODAC_REG_STATUS, 32'h0);
    chk("rst_status", 32'hff00, rd);
    frame(16'h0000);
    chk("rst_echo", 16'h0, host.echo);
    end_of_test();
  end
  // Whole run needs about a tenth of this span
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
endmodule : odac_serial_port_tb

// ===== verilog/odac_defines.svh
// Constant definitions for the octal converter serial load port
`ifndef ODAC_DEFINES_SVH
`define ODAC_DEFINES_SVH

`define ODAC_FRAME_W        16
`define ODAC_FRAME_MSB      15
`define ODAC_CHAN_HI        13
`define ODAC_CHAN_LO        11
`define ODAC_CHAN_TOP       13
`define ODAC_CMD_HI         10
`define ODAC_CMD_LO         8
`define ODAC_CODE_HI        7
`define ODAC_CODE_LO        0
`define ODAC_CHANNELS       8
`define ODAC_CODE_W         8

`define ODAC_CODE_RESET     8'h00
`define ODAC_SHDN_RESET     8'hff
`define ODAC_FRAME_RESET    16'h0000

`define ODAC_ADDR_W         12
`define ODAC_REG_CTRL       12'h000
`define ODAC_REG_STATUS     12'h004
`define ODAC_BASE_INPUT     7'h01
`define ODAC_BASE_OUTPUT    7'h02
`define ODAC_BASE_HI        11
`define ODAC_BASE_LO        5
`define ODAC_IDX_HI         4
`define ODAC_IDX_LO         2
`define ODAC_CTRL_LOAD_BIT  0
`define ODAC_ST_PHASE_BIT   0
`define ODAC_ST_STROBE_BIT  1
`define ODAC_ST_SHDN_LO     8
`define ODAC_ST_SHDN_HI     15

`define ODAC_STROBE_LOW_WIDTH_NS 40

`endif

// ===== verilog/odac_pkg.sv
// Types for the octal converter serial load port
package odac_pkg;

  typedef enum logic [2:0] {
    ODAC_CMD_NOP      = 3'h0,
    ODAC_CMD_CLEAR    = 3'h1,
    ODAC_CMD_SHUTDOWN = 3'h2,
    ODAC_CMD_PHASE    = 3'h3,
    ODAC_CMD_LOAD_ALL = 3'h4,
    ODAC_CMD_LOAD_IN  = 3'h5,
    ODAC_CMD_LOAD_UPD = 3'h6,
    ODAC_CMD_UPD_ALL  = 3'h7
  } odac_cmd_t;

endpackage : odac_pkg

// ===== verilog/odac_serial_port.sv
// Serial load port of an eight-channel converter with APB status access
// Function
// R01: Low load strobe copies inputs to outputs
// R02: Shift only while select is low
// R03: Execute frame at select rising edge
// R04: Sample serial input on shift clock rise
// R05: Output launch falling, rising in mode 1
// R06: Host holds strobe after select rises
// R07: Host limits shift clock rate
// R08: Sixteen bit frame, MSB first, fields
// R09: Serial output delays input sixteen cycles
// R10: Power-on clears codes, selects mode 0
// R11: Decode eight commands of command field
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "odac_defines.svh"

module odac_serial_port
  import odac_pkg::*;
(
  input  wire logic                                   mclk,
  input  wire logic                                   resetn,
  input  wire logic                                   shift_clk,
  input  wire logic                                   select_n,
  input  wire logic                                   serial_in,
  input  wire logic                                   output_load_strobe_n,
  output logic                                        serial_out,
  output logic [`ODAC_CHANNELS*`ODAC_CODE_W-1:0]      conv_code,
  output logic [`ODAC_CHANNELS-1:0]                   chan_enable,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [`ODAC_ADDR_W-1:0]                paddr,
  input  wire logic [31:0]                            pwdata,
  output logic [31:0]                                 prdata,
  output logic                                        pready,
  output logic                                        pslverr
);

  logic [`ODAC_FRAME_W-1:0]  shift_r;
  logic                      out_rise_r;
  logic                      out_fall_r;
  logic                      phase_l1_r;
  logic                      phase_l2_r;
  logic [`ODAC_FRAME_W-1:0]  frame_r;
  logic                      frame_tgl_r;
  logic [2:0]                frame_sync_r;
  logic                      strobe_catch_r;
  logic [1:0]                strobe_sync_r;
  logic                      phase_r;
  logic [`ODAC_CHANNELS-1:0] shdn_r;
  logic [`ODAC_CODE_W-1:0]   in_code_r [`ODAC_CHANNELS];
  logic [31:0]               rd_nxt;
  logic                      rd_err_nxt;
  logic                      exec;
  logic                      strobe_act;
  logic                      soft_load;
  logic                      apb_access;
  odac_cmd_t                 cmd;
  logic [2:0]                chan;
  logic [`ODAC_CODE_W-1:0]   code;

  // Link side, shift clock domain
  always_ff @(posedge shift_clk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= `ODAC_FRAME_RESET;                                 // [R10]
    end else if (!select_n) begin                                   // [R02]
      shift_r <= {shift_r[`ODAC_FRAME_MSB-1:0], serial_in};        // [R04] [R08]
    end
  end

  // Mode from the system side, two stages into the link side
  always_ff @(posedge shift_clk or negedge resetn) begin
    if (!resetn) begin
      phase_l1_r <= 1'b0;
      phase_l2_r <= 1'b0;
    end else begin
      phase_l1_r <= phase_r;
      phase_l2_r <= phase_l1_r;
    end
  end

  // Rising launch: old top bit leaves sixteen edges after capture
  always_ff @(posedge shift_clk or negedge resetn) begin
    if (!resetn) begin
      out_rise_r <= 1'b0;
    end else if (!select_n) begin
      out_rise_r <= shift_r[`ODAC_FRAME_MSB];                       // [R09] [R05]
    end
  end

  always_ff @(negedge shift_clk or negedge resetn) begin
    if (!resetn) begin
      out_fall_r <= 1'b0;
    end else if (!select_n) begin
      out_fall_r <= shift_r[`ODAC_FRAME_MSB];                       // [R09] [R05]
    end
  end

  // Pin holds its level while select is high and shift clock is stopped; mux of two launch flops
  assign serial_out = phase_l2_r ? out_rise_r : out_fall_r;         // [R05]

  // Shift clock may be stopped at frame end, so select's own edge captures the word
  always_ff @(posedge select_n or negedge resetn) begin
    if (!resetn) begin
      frame_r     <= `ODAC_FRAME_RESET;
      frame_tgl_r <= 1'b0;
    end else begin
      frame_r     <= shift_r;                                       // [R03]
      frame_tgl_r <= ~frame_tgl_r;
    end
  end

  // System side
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frame_sync_r <= 3'h0;
    end else begin
      frame_sync_r <= {frame_sync_r[1:0], frame_tgl_r};
    end
  end

  assign exec = frame_sync_r[2] ^ frame_sync_r[1];                  // [R03]
  assign cmd  = odac_cmd_t'(frame_r[`ODAC_CMD_HI:`ODAC_CMD_LO]);
  assign chan = frame_r[`ODAC_CHAN_HI:`ODAC_CHAN_LO];
  assign code = frame_r[`ODAC_CODE_HI:`ODAC_CODE_LO];

  // Strobe may be shorter than a system clock period, so it is caught asynchronously
  always_ff @(posedge mclk or negedge resetn or negedge output_load_strobe_n) begin
    if (!resetn) begin
      strobe_catch_r <= 1'b0;
    end else if (!output_load_strobe_n) begin
      strobe_catch_r <= 1'b1;                                       // [R01]
    end else begin
      strobe_catch_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strobe_sync_r <= 2'h0;
    end else begin
      strobe_sync_r <= {strobe_sync_r[0], strobe_catch_r};
    end
  end

  assign strobe_act = strobe_sync_r[1];                             // [R01] [R06]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 1'b0;                                              // [R10]
    end else if (exec && cmd == ODAC_CMD_PHASE) begin
      phase_r <= frame_r[`ODAC_CHAN_TOP];                           // [R05] [R11]
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shdn_r <= `ODAC_SHDN_RESET;
    end else if (exec && cmd == ODAC_CMD_SHUTDOWN) begin
      shdn_r <= code;                                               // [R11]
    end
  end

  assign chan_enable = shdn_r;

  assign apb_access = psel && penable && !pready;
  assign soft_load  = apb_access && pwrite && paddr == `ODAC_REG_CTRL && pwdata[`ODAC_CTRL_LOAD_BIT];

  // Per channel input and output code registers
  for (genvar ch = 0; ch < `ODAC_CHANNELS; ch++) begin : g_chan
    logic sel_ch;
    assign sel_ch = chan == 3'(ch);

    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        in_code_r[ch] <= `ODAC_CODE_RESET;                          // [R10]
      end else if (exec) begin
        unique case (cmd)                                           // [R11]
          ODAC_CMD_CLEAR:    in_code_r[ch] <= `ODAC_CODE_RESET;
          ODAC_CMD_LOAD_ALL: in_code_r[ch] <= code;
          ODAC_CMD_LOAD_IN,
          ODAC_CMD_LOAD_UPD: if (sel_ch) begin
            in_code_r[ch] <= code;
          end
          ODAC_CMD_NOP,
          ODAC_CMD_SHUTDOWN,
          ODAC_CMD_PHASE,
          ODAC_CMD_UPD_ALL:  in_code_r[ch] <= in_code_r[ch];
        endcase
      end
    end

    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        conv_code[ch*`ODAC_CODE_W +: `ODAC_CODE_W] <= `ODAC_CODE_RESET;        // [R10]
      end else if (exec && cmd == ODAC_CMD_CLEAR) begin
        conv_code[ch*`ODAC_CODE_W +: `ODAC_CODE_W] <= `ODAC_CODE_RESET;        // [R11]
      end else if (exec && cmd == ODAC_CMD_LOAD_ALL) begin
        conv_code[ch*`ODAC_CODE_W +: `ODAC_CODE_W] <= code;                    // [R11]
      end else if (exec && cmd == ODAC_CMD_LOAD_UPD && sel_ch) begin
        conv_code[ch*`ODAC_CODE_W +: `ODAC_CODE_W] <= code;                    // [R11]
      end else if ((exec && cmd == ODAC_CMD_UPD_ALL) || strobe_act || soft_load) begin
        conv_code[ch*`ODAC_CODE_W +: `ODAC_CODE_W] <= in_code_r[ch];           // [R01] [R11]
      end
    end
  end

  // APB read decode
  always_comb begin
    rd_nxt     = 32'h0;
    rd_err_nxt = 1'b0;
    if (paddr == `ODAC_REG_CTRL) begin
      rd_nxt = 32'h0;
    end else if (paddr == `ODAC_REG_STATUS) begin
      rd_nxt[`ODAC_ST_PHASE_BIT]                   = phase_r;
      rd_nxt[`ODAC_ST_STROBE_BIT]                  = strobe_act;
      rd_nxt[`ODAC_ST_SHDN_HI:`ODAC_ST_SHDN_LO]    = shdn_r;
    end else if (paddr[`ODAC_BASE_HI:`ODAC_BASE_LO] == `ODAC_BASE_INPUT && paddr[1:0] == 2'h0) begin
      rd_nxt[`ODAC_CODE_W-1:0] = in_code_r[paddr[`ODAC_IDX_HI:`ODAC_IDX_LO]];
    end else if (paddr[`ODAC_BASE_HI:`ODAC_BASE_LO] == `ODAC_BASE_OUTPUT && paddr[1:0] == 2'h0) begin
      rd_nxt[`ODAC_CODE_W-1:0] = conv_code[paddr[`ODAC_IDX_HI:`ODAC_IDX_LO]*`ODAC_CODE_W +: `ODAC_CODE_W];
    end else begin
      rd_err_nxt = 1'b1;
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access && (rd_err_nxt || (pwrite && paddr != `ODAC_REG_CTRL));
      prdata  <= (apb_access && !pwrite) ? rd_nxt : 32'h0;
    end
  end

endmodule : odac_serial_port
